// ---- rtl/irq_cell_if.sv ----
// Purpose: Carrier between the core control logic and the priority cell array
// Assumes: Single clock domain
// Notes: Core steers the cells, cells return their request latches
`timescale 1ns/100ps
interface irq_cell_if;
  logic level_mode;
  logic freeze;
  logic [7:0] clear_edge;
  logic [7:0] request_latch;

  modport core (output level_mode, output freeze, output clear_edge, input request_latch);
  modport cells (input level_mode, input freeze, input clear_edge, output request_latch);
endinterface

// ---- rtl/irq_cells.sv ----
// Purpose: Eight priority cells: synchroniser, edge sense latch and request latch per input
// Assumes: Request inputs are asynchronous to clk_sys
// Notes: Clear of the edge latch comes from the core at the end of an ack sequence
`timescale 1ns/100ps
module irq_cells
  import irq_pkg::*;
#(
  parameter int LEVELS = NUM_LEVELS
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [LEVELS-1:0] request_inputs,
  irq_cell_if.cells cif
);
  logic [LEVELS-1:0] sync1_q;
  logic [LEVELS-1:0] sync2_q;
  logic [LEVELS-1:0] edge_arm_q;
  logic [LEVELS-1:0] req_latch_q;

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (clk_en) begin
      sync1_q <= request_inputs;
      sync2_q <= sync1_q;
    end
  end

  // Edge sense latch: a low input re-arms, and arming wins over a same-cycle clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      edge_arm_q <= '1;
    end else if (clk_en) begin
      edge_arm_q <= (edge_arm_q & ~cif.clear_edge) | ~sync2_q;
    end
  end

  // Request latch holds still while an ack sequence runs
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      req_latch_q <= '0;
    end else if (clk_en && !cif.freeze) begin
      if (cif.level_mode) begin
        req_latch_q <= sync2_q;
      end else begin
        req_latch_q <= sync2_q & edge_arm_q & ~cif.clear_edge;
      end
    end
  end

  assign cif.request_latch = req_latch_q;
endmodule // irq_cells

// ---- rtl/irq_pkg.sv ----
// Purpose: Shared constants, state type and helper function for the interrupt priority core
// Assumes: Eight request levels, level 0 the highest priority
// Notes: No timing constants are needed; every step is tied to ack strobe edges
package irq_pkg;
  localparam int NUM_LEVELS = 8;
  localparam int LVL_W = 3;
  localparam logic [7:0] CALL_OPCODE = 8'hcd;
  localparam logic [1:0] PULSES_CALL = 2'h3;
  localparam logic [1:0] PULSES_VECTOR = 2'h2;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] VECTOR_IDLE = 8'h00;
  localparam logic [2:0] SPURIOUS_LVL = 3'h7;
  // Bit fields of the vector bytes
  localparam int TYPE_BASE_LSB = 3;
  localparam int INT4_BASE_LSB = 5;
  localparam int INT8_BASE_LSB = 6;

  // Gray path: idle -> strobe low -> strobe high -> strobe low ...
  typedef enum logic [1:0] {
    ACK_IDLE = 2'b00,
    ACK_LOW = 2'b01,
    ACK_HIGH = 2'b11
  } ack_state_e;

  // Lowest set index wins; returns {found, index}
  function automatic logic [LVL_W:0] lowest_set(input logic [NUM_LEVELS-1:0] vec);
    logic [LVL_W:0] res;
    res = '0;
    for (int i = NUM_LEVELS - 1; i >= 0; i--) begin
      if (vec[i]) begin
        res = {1'b1, LVL_W'(i)};
      end
    end
    return res;
  endfunction
endpackage

// ---- rtl/irq_priority_core.sv ----
// Purpose: Request handling core of an eight-level interrupt controller
// Assumes: Ack strobe, mask and end-of-service ports are synchronous to clk_sys
// Notes: Non-specific end of service clears the highest-priority in-service bit
`timescale 1ns/100ps

module irq_priority_core
  import irq_pkg::*;
#(
  parameter int LEVELS = NUM_LEVELS
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [LEVELS-1:0] request_inputs,
  input wire logic ack_strobe_n,
  input wire logic chip_select_n,
  input wire logic level_mode,
  input wire logic two_pulse_mode,
  input wire logic interval_4,
  input wire logic [15:0] call_addr_base,
  input wire logic [7:0] type_base,
  input wire logic mask_load,
  input wire logic [LEVELS-1:0] mask_data,
  input wire logic end_of_service_cmd,
  output logic int_out,
  output logic [7:0] data_out,
  output logic data_oe_n,
  output logic ack_busy,
  output logic [LEVELS-1:0] pending_request_reg,
  output logic [LEVELS-1:0] in_service_reg,
  output logic [LEVELS-1:0] request_mask_reg
);
  irq_cell_if cif ();

  ack_state_e state_q;
  ack_state_e state_d;
  logic ack_prev_q;
  logic [1:0] pulse_cnt_q;
  logic [LVL_W-1:0] win_lvl_q;
  logic win_valid_q;
  logic int_q;
  logic [7:0] data_q;
  logic oe_n_q;
  logic [LEVELS-1:0] pend_q;
  logic [LEVELS-1:0] isr_q;
  logic [LEVELS-1:0] imr_q;
  logic [LEVELS-1:0] eligible;
  logic [LVL_W:0] req_top;
  logic [LVL_W:0] isr_top;
  logic raise;
  logic ack_fall;
  logic ack_rise;
  logic [1:0] pulses_needed;
  logic seq_done;
  logic [LEVELS-1:0] isr_set;
  logic [LEVELS-1:0] isr_clr;
  logic [7:0] vec_byte;
  logic busy_q;

  // Cell array with per-input latches
  irq_cells #(.LEVELS(LEVELS)) u_cells (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .request_inputs(request_inputs),
    .cif(cif)
  );

  // Chip select plays no part: ack handling never looks at it
  assign cif.level_mode = level_mode;
  assign cif.freeze = (state_q != ACK_IDLE);
  assign cif.clear_edge = isr_set;

  // Priority resolver
  assign eligible = cif.request_latch & ~imr_q;
  assign req_top = lowest_set(eligible);
  assign isr_top = lowest_set(isr_q);
  // A request wins only when it outranks every level in service
  assign raise = req_top[LVL_W] &&
                 (!isr_top[LVL_W] || (req_top[LVL_W-1:0] < isr_top[LVL_W-1:0]));

  // Ack strobe edges; strobe is taken as already synchronous
  assign ack_fall = ack_prev_q && !ack_strobe_n;
  assign ack_rise = !ack_prev_q && ack_strobe_n;
  assign pulses_needed = two_pulse_mode ? PULSES_VECTOR : PULSES_CALL;
  assign seq_done = (state_q == ACK_LOW) && ack_rise && (pulse_cnt_q == pulses_needed);

  // Sequence state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ACK_IDLE: begin
        if (ack_fall) begin
          state_d = ACK_LOW;
        end
      end
      ACK_LOW: begin
        if (seq_done) begin
          state_d = ACK_IDLE;
        end else if (ack_rise) begin
          state_d = ACK_HIGH;
        end
      end
      ACK_HIGH: begin
        if (ack_fall) begin
          state_d = ACK_LOW;
        end
      end
      default: begin
        state_d = ACK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= ACK_IDLE;
      busy_q <= 1'b0;
      ack_prev_q <= 1'b1;
      pulse_cnt_q <= 2'h0;
    end else if (clk_en) begin
      state_q <= state_d;
      busy_q <= (state_d != ACK_IDLE);
      ack_prev_q <= ack_strobe_n;
      if (ack_fall) begin
        pulse_cnt_q <= (state_q == ACK_IDLE) ? 2'h1 : pulse_cnt_q + 2'h1;
      end
    end
  end

  // Winner taken at the first pulse from the latches, which load once more at that edge and then freeze
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      win_lvl_q <= SPURIOUS_LVL;
      win_valid_q <= 1'b0;
    end else if (clk_en && ack_fall && state_q == ACK_IDLE) begin
      win_valid_q <= raise;
      win_lvl_q <= raise ? req_top[LVL_W-1:0] : SPURIOUS_LVL;
    end
  end

  // Byte for the pulse now starting; the count before this edge names the pulse just ended
  always_comb begin
    vec_byte = VECTOR_IDLE;
    if (two_pulse_mode) begin
      vec_byte = {type_base[7:TYPE_BASE_LSB], win_lvl_q};
    end else if (pulse_cnt_q == 2'h1) begin
      if (interval_4) begin
        vec_byte = {call_addr_base[7:INT4_BASE_LSB], win_lvl_q, 2'b00};
      end else begin
        vec_byte = {call_addr_base[7:INT8_BASE_LSB], win_lvl_q, 3'b000};
      end
    end else begin
      vec_byte = call_addr_base[15:8];
    end
  end

  // Data drive: enabled only while a data-bearing strobe is low
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      data_q <= VECTOR_IDLE;
      oe_n_q <= 1'b1;
    end else if (clk_en) begin
      if (ack_fall && state_q == ACK_IDLE) begin
        data_q <= CALL_OPCODE;
        oe_n_q <= two_pulse_mode;
      end else if (ack_fall) begin
        data_q <= vec_byte;
        oe_n_q <= 1'b0;
      end else if (ack_rise) begin
        oe_n_q <= 1'b1;
      end
    end
  end

  // In-service updates: set at sequence end wins over a same-cycle clear
  assign isr_set = (seq_done && win_valid_q) ? (LEVELS'(1) << win_lvl_q) : '0;
  assign isr_clr = (end_of_service_cmd && isr_top[LVL_W]) ?
                   (LEVELS'(1) << isr_top[LVL_W-1:0]) : '0;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      isr_q <= '0;
    end else if (clk_en) begin
      isr_q <= (isr_q & ~isr_clr) | isr_set;
    end
  end

  // Mask register loaded from the configuration port
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      imr_q <= MASK_RESET;
    end else if (clk_en && mask_load) begin
      imr_q <= mask_data;
    end
  end

  // Interrupt output held low while an ack sequence runs
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      int_q <= 1'b0;
      pend_q <= '0;
    end else if (clk_en) begin
      int_q <= raise && (state_d == ACK_IDLE) && !seq_done;
      pend_q <= cif.request_latch;
    end
  end

  assign int_out = int_q;
  assign data_out = data_q;
  assign data_oe_n = oe_n_q;
  // Own flop so the busy output carries no decode after the state register
  assign ack_busy = busy_q;
  assign pending_request_reg = pend_q;
  assign in_service_reg = isr_q;
  assign request_mask_reg = imr_q;
endmodule // irq_priority_core

// ---- tb/ack_host_model.sv ----
// Purpose: Host side that answers the interrupt with ack trains
// Assumes: Called from the bench just after a clock edge
// Notes: Keeps every byte it sees and whether the bus was driven
`timescale 1ns/100ps
module ack_host_model (
  input wire logic clk_sys,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  output logic ack_strobe_n,
  output logic lock_n
);
  logic [7:0] vb [3];
  logic [2:0] drv;
  logic [9:0] table_addr;
  // Idle bus: strobe and lock high
  initial begin
    ack_strobe_n = 1'b1;
    lock_n = 1'b1;
  end
  // One train of n pulses; slow stretches each low phase
  task automatic ack_seq(input int n, input int slow);
    lock_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys) ack_strobe_n <= 1'b0;
      repeat (slow + 2) @(posedge clk_sys);
      vb[i] = data_out;
      drv[i] = !data_oe_n;
      ack_strobe_n <= 1'b1;
      @(posedge clk_sys);
    end
    table_addr = {vb[n-1], 2'b00};
    lock_n <= 1'b1;
  endtask
endmodule // ack_host_model

// ---- tb/interrupt_priority_core_test.sv ----
// Purpose: Self-checking bench for the interrupt core
// Assumes: Host model issues the ack trains
// Notes: Expected bytes are built from the vector formats
`timescale 1ns/100ps
module interrupt_priority_core_test
  import irq_pkg::*;
;
  logic clk_sys, rst_n, clk_en, chip_select_n, level_mode, two_pulse_mode, interval_4;
  logic mask_load, end_of_service_cmd, int_out, data_oe_n, ack_busy, ack_strobe_n;
  logic [7:0] request_inputs, type_base, mask_data, data_out;
  logic [7:0] pending_request_reg, in_service_reg, request_mask_reg;
  logic [15:0] call_addr_base;
  int error_cnt = 0;
  int cmp_count = 0;
  irq_priority_core i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .request_inputs(request_inputs), .ack_strobe_n(ack_strobe_n),
    .chip_select_n(chip_select_n), .level_mode(level_mode), .two_pulse_mode(two_pulse_mode),
    .interval_4(interval_4), .call_addr_base(call_addr_base), .type_base(type_base),
    .mask_load(mask_load), .mask_data(mask_data), .end_of_service_cmd(end_of_service_cmd),
    .int_out(int_out), .data_out(data_out), .data_oe_n(data_oe_n), .ack_busy(ack_busy),
    .pending_request_reg(pending_request_reg), .in_service_reg(in_service_reg),
    .request_mask_reg(request_mask_reg));
  ack_host_model i_host (.clk_sys(clk_sys), .data_out(data_out), .data_oe_n(data_oe_n),
    .ack_strobe_n(ack_strobe_n), .lock_n());
  // 125 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pulse_eos;
    end_of_service_cmd <= 1'b1;
    cyc(1);
    end_of_service_cmd <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Hang guard, far past the roughly 120 cycles needed
  initial begin
    cyc(20000);
    error_cnt++;
    report_and_stop();
  end
  // Edge/call part, then level/vector part with mask and priority
  initial begin
    {rst_n, chip_select_n, level_mode, two_pulse_mode, mask_load} = 5'h00;
    {end_of_service_cmd, interval_4, request_inputs, mask_data} = 18'h1_0000;
    call_addr_base = 16'habe0;
    clk_en = 1'b1;
    type_base = 8'h48;
    cyc(4);
    rst_n <= 1'b1;
    cyc(2);
    chk({int_out, data_oe_n, ack_busy, data_out, pending_request_reg, in_service_reg,
      request_mask_reg}, 40'h02_0000_0000);
    request_inputs <= 8'h04;
    cyc(6);
    chk(int_out, 1'b1);
    chip_select_n <= 1'b1;
    i_host.ack_seq(3, 0);
    chk({i_host.vb[0], i_host.vb[1], i_host.vb[2]},
      {CALL_OPCODE, call_addr_base[7:5], 5'b01000, call_addr_base[15:8]});
    cyc(2);
    chk(in_service_reg, 8'h04);
    pulse_eos();
    cyc(5);
    chk({in_service_reg, int_out}, 9'h000);
    request_inputs <= 8'h00;
    interval_4 <= 1'b0;
    cyc(4);
    request_inputs <= 8'h04;
    cyc(6);
    i_host.ack_seq(3, 2);
    chk(i_host.vb[1], {call_addr_base[7:6], 6'b010000});
    pulse_eos();
    level_mode <= 1'b1;
    two_pulse_mode <= 1'b1;
    cyc(6);
    chk(int_out, 1'b1);
    fork
      i_host.ack_seq(2, 1);
      begin
        cyc(1);
        request_inputs <= 8'h05;
      end
    join
    chk({i_host.drv[1:0], i_host.vb[1]}, {2'b10, type_base[7:3], 3'd2});
    cyc(6);
    chk({in_service_reg, int_out}, 9'h009);
    i_host.ack_seq(2, 0);
    chk(i_host.vb[1], {type_base[7:3], 3'd0});
    chk(i_host.table_addr, {type_base[7:3], 3'd0, 2'b00});
    cyc(2);
    chk(in_service_reg, 8'h05);
    pulse_eos();
    cyc(4);
    chk({in_service_reg, int_out}, 9'h009);
    mask_data <= 8'h01;
    mask_load <= 1'b1;
    cyc(1);
    mask_load <= 1'b0;
    request_inputs <= 8'h25;
    cyc(6);
    chk({request_mask_reg, int_out}, 9'h002);
    pulse_eos();
    cyc(4);
    chk({in_service_reg, int_out}, 9'h001);
    // Clock enable low must hold every register while the input drops
    clk_en <= 1'b0;
    request_inputs <= 8'h00;
    cyc(6);
    chk({pending_request_reg, int_out}, 9'h04b);
    clk_en <= 1'b1;
    cyc(6);
    chk({pending_request_reg, int_out}, 9'h000);
    report_and_stop();
  end
endmodule // interrupt_priority_core_test

// ---- tb/irq_core_asserts.sv ----
// Purpose: Port checks for the interrupt core
// Assumes: One clock; clk_en low pauses the checks
// Notes: Flops rebuild the mask and IN_SERVICE_REG that the resolver saw
`timescale 1ns/100ps
module irq_core_asserts
  import irq_pkg::*;
#(
  parameter int LEVELS = NUM_LEVELS
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic ack_strobe_n,
  input wire logic two_pulse_mode,
  input wire logic [7:0] type_base,
  input wire logic end_of_service_cmd,
  input wire logic int_out,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  input wire logic ack_busy,
  input wire logic [LEVELS-1:0] pending_request_reg,
  input wire logic [LEVELS-1:0] in_service_reg,
  input wire logic [LEVELS-1:0] request_mask_reg
);
  logic prev_q;
  logic [1:0] pulse_q;
  logic [LEVELS-1:0] mask_p_q, isr_p_q, req, win, isr_w;
  wire logic fall = prev_q & ~ack_strobe_n;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n || !clk_en);
  // Lowest set bit is the best ranked level
  assign req = pending_request_reg & ~mask_p_q;
  assign win = req & (~req + 1'b1);
  assign isr_w = isr_p_q & (~isr_p_q + 1'b1);
  // Strobe history and pulse number, delayed mask and IN_SERVICE_REG
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prev_q <= 1'b1;
      pulse_q <= 2'd0;
      mask_p_q <= '0;
      isr_p_q <= '0;
    end else if (clk_en) begin
      prev_q <= ack_strobe_n;
      pulse_q <= fall ? (ack_busy ? pulse_q + 2'd1 : 2'd1) : pulse_q;
      mask_p_q <= request_mask_reg;
      isr_p_q <= in_service_reg;
    end
  end
  property p_int_gate;
    int_out |-> win != '0 && (isr_p_q == '0 || win < isr_w);
  endproperty
  a_int_gate: assert property (p_int_gate) else $error("int without cause");
  property p_int_rise;
    !ack_busy && !$past(ack_busy) && win != '0 && (isr_p_q == '0 || win < isr_w) |-> int_out;
  endproperty
  a_int_rise: assert property (p_int_rise) else $error("int missing");
  property p_int_quiet;
    ack_busy |-> !int_out;
  endproperty
  a_int_quiet: assert property (p_int_quiet) else $error("int in ack");
  property p_first_quiet;
    two_pulse_mode && ack_busy && pulse_q == 2'd1 |-> data_oe_n;
  endproperty
  a_first_quiet: assert property (p_first_quiet) else $error("bus driven on pulse one");
  property p_vector;
    two_pulse_mode && $past(fall) && pulse_q == 2'd2 |-> !data_oe_n && data_out[7:3] == type_base[7:3];
  endproperty
  a_vector: assert property (p_vector) else $error("vector byte wrong");
  property p_frozen;
    ack_busy && $past(ack_busy, 2) |-> $stable(pending_request_reg);
  endproperty
  a_frozen: assert property (p_frozen) else $error("latches moved in ack");
  property p_isr_set;
    (in_service_reg & ~$past(in_service_reg)) != '0 |-> $fell(ack_busy);
  endproperty
  a_isr_set: assert property (p_isr_set) else $error("IN_SERVICE_REG set off sequence end");
  property p_isr_clear;
    ($past(in_service_reg) & ~in_service_reg) != '0 |-> $past(end_of_service_cmd);
  endproperty
  a_isr_clear: assert property (p_isr_clear) else $error("IN_SERVICE_REG cleared without command");
endmodule // irq_core_asserts

bind irq_priority_core irq_core_asserts #(.LEVELS(LEVELS)) i_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .ack_strobe_n(ack_strobe_n),
  .two_pulse_mode(two_pulse_mode), .type_base(type_base),
  .end_of_service_cmd(end_of_service_cmd), .int_out(int_out), .data_out(data_out),
  .data_oe_n(data_oe_n), .ack_busy(ack_busy), .pending_request_reg(pending_request_reg),
  .in_service_reg(in_service_reg), .request_mask_reg(request_mask_reg));
